// *** rtl/sbcm_cfg.svh ***
// constants of the standstill, brake and capture monitor
// assumes a single 125 MHz device clock and a 16-bit parameter address
`ifndef SBCM_CFG_SVH
`define SBCM_CFG_SVH
// ======================================================================
// parameter addresses
`define SBCM_ADDR_CAP_STATUS 16'h0A02
`define SBCM_ADDR_SECOND_CAPTURE_INPUT_POS 16'h0A0E
`define SBCM_ADDR_WIN_SIZE 16'h1112
`define SBCM_ADDR_DWELL 16'h1114
`define SBCM_ADDR_TIMEOUT 16'h1116
// ======================================================================
// field positions of capture_unit_status
`define SBCM_FIRST_CAPTURE_INPUT_DONE_BIT 0
`define SBCM_SECOND_CAPTURE_INPUT_DONE_BIT 1
// ======================================================================
// limits and factory values
`define SBCM_WIN_MAX 16'h7FFF
`define SBCM_WIN_RESET 16'h000A
`define SBCM_DWELL_MAX 16'h7FFF
`define SBCM_DWELL_RESET 16'h0000
`define SBCM_TOUT_MAX 16'h3E80
`define SBCM_TOUT_RESET 16'h0000
// ======================================================================
// error classes
`define SBCM_ERR_CLASS2 3'h2
`define SBCM_ERR_CLASS3 3'h3
`define SBCM_ERR_CLASS4 3'h4
// ======================================================================
// timing
`define SBCM_CLK_HZ 125000000
`define SBCM_TICK_MS 1
`define SBCM_TICK_CYCLES (`SBCM_CLK_HZ / 1000 * `SBCM_TICK_MS)
`define SBCM_BRAKE_RELEASE_MS 16'h0064
`define SBCM_BRAKE_APPLY_MS 16'h0064
`endif

// *** rtl/sbcm_pkg.sv ***
// types of the standstill, brake and capture monitor
// assumes the constants of sbcm_cfg.svh
package sbcm_pkg;
  // ======================================================================
  // state types
  typedef enum logic [2:0] {
    SST_IDLE = 3'b000,
    SST_MOVING = 3'b001,
    SST_SEEK = 3'b010,
    SST_DWELL = 3'b011,
    SST_DONE = 3'b100,
    SST_FAULT = 3'b101
  } sbcm_sst_e;
  typedef enum logic [1:0] {
    BRK_OFF = 2'b00,
    BRK_RELEASE = 2'b01,
    BRK_RUN = 2'b10,
    BRK_APPLY = 2'b11
  } sbcm_brk_e;
  typedef logic [15:0] sbcm_word_t;
endpackage : sbcm_pkg

// *** rtl/sbcm_tick_div.sv ***
// millisecond tick divider
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sbcm_tick_div #(
  parameter int DIV = 125000
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  output logic o_tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] count;
  // ======================================================================
  // free running count, one-cycle pulse at wrap
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (count == LAST);
      count <= (count == LAST) ? '0 : count + CW'(1);
    end
  end
endmodule : sbcm_tick_div
`default_nettype wire

// *** rtl/sbcm_ms_timer.sv ***
// one-shot timer counted in millisecond ticks
// assumes a one-cycle tick pulse; first tick may come early, so up to 1 ms short
`timescale 1ns/100ps
`default_nettype none
module sbcm_ms_timer #(
  parameter int W = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [W-1:0] i_ms,
  output logic o_running,
  output logic o_expired
);
  logic [W-1:0] count;
  // ======================================================================
  // start wins over stop; a zero load never runs
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count <= '0;
      o_running <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_start) begin
        count <= i_ms;
        o_running <= (i_ms != '0);
      end else if (i_stop) begin
        o_running <= 1'b0;
      end else if (o_running && i_tick) begin
        count <= count - W'(1);
        if (count == W'(1)) begin
          o_running <= 1'b0;
          o_expired <= 1'b1;
        end
      end
    end
  end
endmodule : sbcm_ms_timer
`default_nettype wire

// *** rtl/sbcm_monitor.sv ***
// standstill window, holding brake sequencer and capture results
// assumes inputs synchronous to i_clock, events as one-cycle pulses,
// deviation in units of 0.0001 revolution, parameter access by address
`timescale 1ns/100ps
`default_nettype none
`include "sbcm_cfg.svh"
module sbcm_monitor #(
  parameter int TICK_CYCLES = `SBCM_TICK_CYCLES,
  parameter logic [15:0] BRAKE_RELEASE_MS = `SBCM_BRAKE_RELEASE_MS,
  parameter logic [15:0] BRAKE_APPLY_MS = `SBCM_BRAKE_APPLY_MS
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // parameter access
  input wire logic [15:0] i_par_addr,
  input wire logic i_par_rd,
  input wire logic i_par_wr,
  input wire logic [31:0] i_par_wdata,
  output logic [31:0] o_par_rdata,
  output logic o_par_ack,
  output logic o_par_fault,
  // capture units
  input wire logic [31:0] i_motor_pos,
  input wire logic i_first_capture_input,
  input wire logic i_second_capture_input,
  input wire logic i_first_capture_input_arm,
  input wire logic i_second_capture_input_arm,
  input wire logic i_pos_redefine,
  input wire logic [31:0] i_pos_shift,
  // standstill window
  input wire logic i_move_start,
  input wire logic i_target_reached,
  input wire logic i_profile_done,
  input wire logic [31:0] i_pos_dev,
  output logic o_proc_done,
  output logic o_standstill_err,
  // holding brake and power stage
  input wire logic i_enable,
  input wire logic [2:0] i_err_class,
  input wire logic i_safe_torque_off,
  output logic o_brake_release,
  output logic o_motor_current_on,
  output logic o_operation_enabled,
  output sbcm_pkg::sbcm_brk_e o_brake_state
);
  import sbcm_pkg::*;

  // ======================================================================
  // parameter registers
  sbcm_word_t standstill_window_size;
  sbcm_word_t standstill_dwell_time;
  sbcm_word_t standstill_timeout_time;
  sbcm_word_t capture_unit_status;
  logic [31:0] second_captured_position;
  logic [31:0] next_rdata;
  logic next_fault;
  logic wr_ok;
  logic [15:0] wval;

  assign wval = i_par_wdata[15:0];

  // write acceptance: range checked, read-only and unmapped refused
  always_comb begin
    wr_ok = 1'b0;
    case (i_par_addr)
      `SBCM_ADDR_WIN_SIZE: wr_ok = (i_par_wdata <= 32'(`SBCM_WIN_MAX));
      `SBCM_ADDR_DWELL: wr_ok = (i_par_wdata <= 32'(`SBCM_DWELL_MAX));
      `SBCM_ADDR_TIMEOUT: wr_ok = (i_par_wdata <= 32'(`SBCM_TOUT_MAX));
      default: wr_ok = 1'b0;
    endcase
  end

  // factory values at reset; persistence lives outside this block
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      standstill_window_size <= `SBCM_WIN_RESET;
      standstill_dwell_time <= `SBCM_DWELL_RESET;
      standstill_timeout_time <= `SBCM_TOUT_RESET;
    end else if (i_par_wr && wr_ok) begin
      case (i_par_addr)
        `SBCM_ADDR_WIN_SIZE: standstill_window_size <= wval;
        `SBCM_ADDR_DWELL: standstill_dwell_time <= wval;
        `SBCM_ADDR_TIMEOUT: standstill_timeout_time <= wval;
        default: standstill_window_size <= standstill_window_size;
      endcase
    end
  end

  // read mux; unmapped reads return zero with fault
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_fault = 1'b0;
    case (i_par_addr)
      `SBCM_ADDR_CAP_STATUS: next_rdata = {16'h0000, capture_unit_status};
      `SBCM_ADDR_SECOND_CAPTURE_INPUT_POS: next_rdata = second_captured_position;
      `SBCM_ADDR_WIN_SIZE: next_rdata = {16'h0000, standstill_window_size};
      `SBCM_ADDR_DWELL: next_rdata = {16'h0000, standstill_dwell_time};
      `SBCM_ADDR_TIMEOUT: next_rdata = {16'h0000, standstill_timeout_time};
      default: next_fault = 1'b1;
    endcase
    if (i_par_wr) begin
      next_fault = !wr_ok;
    end
  end

  // answer one cycle after the request; write takes precedence
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_par_rdata <= 32'h0000_0000;
      o_par_ack <= 1'b0;
      o_par_fault <= 1'b0;
    end else begin
      o_par_ack <= i_par_rd || i_par_wr;
      o_par_fault <= (i_par_rd || i_par_wr) && next_fault;
      if (i_par_rd && !i_par_wr) begin
        o_par_rdata <= next_rdata;
      end
    end
  end

  // ======================================================================
  // capture results
  // capture wins over a same-cycle redefinition: the sampled position
  // is assumed to already be in the new reference frame
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      second_captured_position <= 32'h0000_0000;
    end else if (i_second_capture_input) begin
      second_captured_position <= i_motor_pos;
    end else if (i_pos_redefine) begin
      second_captured_position <= second_captured_position + i_pos_shift;
    end
  end

  // done flags; re-arming clears, a capture in the same cycle wins
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      capture_unit_status <= 16'h0000;
    end else begin
      if (i_first_capture_input) begin
        capture_unit_status[`SBCM_FIRST_CAPTURE_INPUT_DONE_BIT] <= 1'b1;
      end else if (i_first_capture_input_arm) begin
        capture_unit_status[`SBCM_FIRST_CAPTURE_INPUT_DONE_BIT] <= 1'b0;
      end
      if (i_second_capture_input) begin
        capture_unit_status[`SBCM_SECOND_CAPTURE_INPUT_DONE_BIT] <= 1'b1;
      end else if (i_second_capture_input_arm) begin
        capture_unit_status[`SBCM_SECOND_CAPTURE_INPUT_DONE_BIT] <= 1'b0;
      end
    end
  end

  // ======================================================================
  // millisecond timebase and timers
  logic ms_tick;
  logic dwell_start;
  logic dwell_stop;
  logic dwell_expired;
  logic tout_start;
  logic tout_stop;
  logic tout_expired;
  logic brk_start;
  logic [15:0] brk_ms;
  logic brk_expired;

  sbcm_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .o_tick(ms_tick)
  );

  sbcm_ms_timer #(.W(16)) u_dwell (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_tick(ms_tick),
    .i_start(dwell_start),
    .i_stop(dwell_stop),
    .i_ms(standstill_dwell_time),
    .o_running(),
    .o_expired(dwell_expired)
  );

  sbcm_ms_timer #(.W(16)) u_tout (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_tick(ms_tick),
    .i_start(tout_start),
    .i_stop(tout_stop),
    .i_ms(standstill_timeout_time),
    .o_running(),
    .o_expired(tout_expired)
  );

  sbcm_ms_timer #(.W(16)) u_brake (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_tick(ms_tick),
    .i_start(brk_start),
    .i_stop(1'b0),
    .i_ms(brk_ms),
    .o_running(),
    .o_expired(brk_expired)
  );

  // ======================================================================
  // standstill window
  sbcm_sst_e sst;
  sbcm_sst_e next_sst;
  logic in_window;
  logic move_end;

  // signed window compare avoids the abs() overflow at the most negative value
  assign in_window = ($signed(i_pos_dev) <= $signed({16'h0000, standstill_window_size}))
    && ($signed(i_pos_dev) >= -$signed({16'h0000, standstill_window_size}));
  assign move_end = i_target_reached || i_profile_done;

  // next state and timer controls
  always_comb begin
    next_sst = sst;
    dwell_start = 1'b0;
    dwell_stop = 1'b0;
    tout_start = 1'b0;
    tout_stop = 1'b0;
    if (i_move_start) begin
      next_sst = SST_MOVING;
      dwell_stop = 1'b1;
      tout_stop = 1'b1;
    end else begin
      case (sst)
        SST_IDLE, SST_MOVING: begin
          if (move_end) begin
            if (standstill_dwell_time == 16'h0000) begin
              next_sst = SST_DONE;
            end else begin
              next_sst = SST_SEEK;
              tout_start = 1'b1;
            end
          end
        end
        SST_SEEK: begin
          if (tout_expired) begin
            next_sst = SST_FAULT;
          end else if (in_window) begin
            next_sst = SST_DWELL;
            dwell_start = 1'b1;
          end
        end
        SST_DWELL: begin
          if (tout_expired) begin
            next_sst = SST_FAULT;
            dwell_stop = 1'b1;
          end else if (!in_window) begin
            next_sst = SST_SEEK;
            dwell_stop = 1'b1;
          end else if (dwell_expired) begin
            next_sst = SST_DONE;
            tout_stop = 1'b1;
          end
        end
        SST_DONE, SST_FAULT: begin
          next_sst = sst;
        end
        default: begin
          next_sst = SST_IDLE;
        end
      endcase
    end
  end

  // state and registered flags
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sst <= SST_IDLE;
      o_proc_done <= 1'b0;
      o_standstill_err <= 1'b0;
    end else begin
      sst <= next_sst;
      o_proc_done <= (next_sst == SST_DONE);
      o_standstill_err <= (next_sst == SST_FAULT);
    end
  end

  // ======================================================================
  // holding brake sequencer
  sbcm_brk_e brk;
  sbcm_brk_e next_brk;
  logic fast_off;
  logic slow_off;

  // safe torque off cuts torque at once, so no delay can bridge to the brake
  assign fast_off = i_safe_torque_off || (i_err_class == `SBCM_ERR_CLASS3)
    || (i_err_class == `SBCM_ERR_CLASS4);
  assign slow_off = !i_enable || (i_err_class == `SBCM_ERR_CLASS2);

  always_comb begin
    next_brk = brk;
    brk_start = 1'b0;
    brk_ms = BRAKE_RELEASE_MS;
    case (brk)
      BRK_OFF: begin
        if (i_enable && !i_safe_torque_off && (i_err_class == 3'h0)) begin
          next_brk = BRK_RELEASE;
          brk_start = 1'b1;
        end
      end
      BRK_RELEASE, BRK_RUN: begin
        if (fast_off) begin
          next_brk = BRK_OFF;
        end else if (slow_off) begin
          next_brk = BRK_APPLY;
          brk_start = 1'b1;
          brk_ms = BRAKE_APPLY_MS;
        end else if ((brk == BRK_RELEASE) && brk_expired) begin
          next_brk = BRK_RUN;
        end
      end
      BRK_APPLY: begin
        if (fast_off || brk_expired) begin
          next_brk = BRK_OFF;
        end
      end
      default: begin
        next_brk = BRK_OFF;
      end
    endcase
  end

  // outputs follow the next state so they leave a flip-flop in step with it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      brk <= BRK_OFF;
      o_brake_state <= BRK_OFF;
      o_brake_release <= 1'b0;
      o_motor_current_on <= 1'b0;
      o_operation_enabled <= 1'b0;
    end else begin
      brk <= next_brk;
      o_brake_state <= next_brk;
      o_brake_release <= (next_brk == BRK_RELEASE) || (next_brk == BRK_RUN);
      o_motor_current_on <= (next_brk != BRK_OFF);
      o_operation_enabled <= (next_brk == BRK_RUN);
    end
  end
endmodule : sbcm_monitor
`default_nettype wire

// *** verification/sbcm_monitor_properties.sv ***
// port assertions of the standstill, brake and capture monitor
// assumes binding into sbcm_monitor, one clock, sync active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "sbcm_cfg.svh"
module sbcm_monitor_properties #(
  parameter int TICK_CYCLES = `SBCM_TICK_CYCLES,
  parameter logic [15:0] BRAKE_RELEASE_MS = `SBCM_BRAKE_RELEASE_MS,
  parameter logic [15:0] BRAKE_APPLY_MS = `SBCM_BRAKE_APPLY_MS
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_par_addr,
  input wire logic i_par_rd,
  input wire logic i_par_wr,
  input wire logic [31:0] i_par_wdata,
  input wire logic [31:0] o_par_rdata,
  input wire logic o_par_ack,
  input wire logic o_par_fault,
  input wire logic [31:0] i_motor_pos,
  input wire logic i_second_capture_input,
  input wire logic i_enable,
  input wire logic [2:0] i_err_class,
  input wire logic i_safe_torque_off,
  input wire logic o_brake_release,
  input wire logic o_motor_current_on,
  input wire logic o_operation_enabled,
  input wire sbcm_pkg::sbcm_brk_e o_brake_state
);
  import sbcm_pkg::*;
  // ========================================
  // single domain: one clocking, reset disables all
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_ack_follows_req: assert property (o_par_ack == $past(i_par_rd | i_par_wr))
    else $error("ack not one cycle after request");
  a_ro_write_fault: assert property (i_par_wr && (i_par_addr == `SBCM_ADDR_CAP_STATUS
    || i_par_addr == `SBCM_ADDR_SECOND_CAPTURE_INPUT_POS) |=> o_par_fault && o_par_ack)
    else $error("write to read-only word not refused");
  a_limit_fault: assert property (i_par_wr && (i_par_addr == `SBCM_ADDR_TIMEOUT
    && i_par_wdata > 32'h3E80 || i_par_addr == `SBCM_ADDR_DWELL && i_par_wdata > 32'h7FFF
    || i_par_addr == `SBCM_ADDR_WIN_SIZE && i_par_wdata > 32'h7FFF) |=> o_par_fault)
    else $error("value above limit not refused");
  a_second_capture_input_readback: assert property (i_second_capture_input ##1 (i_par_rd && !i_par_wr
    && i_par_addr == `SBCM_ADDR_SECOND_CAPTURE_INPUT_POS) |=> o_par_rdata == $past(i_motor_pos, 2))
    else $error("captured position differs from position at capture");
  a_fast_cut: assert property (o_motor_current_on && (i_safe_torque_off
    || i_err_class == 3'h3 || i_err_class == 3'h4) |=> !o_motor_current_on && !o_brake_release)
    else $error("current not cut at once");
  a_delayed_cut: assert property (o_brake_state == BRK_RUN && !i_safe_torque_off
    && (i_err_class == 3'h2 || !i_enable && i_err_class == 3'h0)
    |=> o_motor_current_on && !o_brake_release && !o_operation_enabled)
    else $error("brake not applied with current held");
  a_release_enable: assert property (o_brake_state == BRK_OFF && i_enable
    && !i_safe_torque_off && i_err_class == 3'h0 |=> o_brake_release && o_motor_current_on)
    else $error("brake not released on enable");
  a_op_after_release: assert property ($rose(o_operation_enabled) |->
    o_brake_release && $past(o_brake_release, 8))
    else $error("operation enabled before release delay");
  a_release_needs_current: assert property (o_brake_release |-> o_motor_current_on)
    else $error("brake released without motor current");
endmodule : sbcm_monitor_properties
bind sbcm_monitor sbcm_monitor_properties #(.TICK_CYCLES(TICK_CYCLES),
  .BRAKE_RELEASE_MS(BRAKE_RELEASE_MS), .BRAKE_APPLY_MS(BRAKE_APPLY_MS)) u_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_par_addr(i_par_addr), .i_par_rd(i_par_rd),
  .i_par_wr(i_par_wr), .i_par_wdata(i_par_wdata), .o_par_rdata(o_par_rdata), .o_par_ack(o_par_ack),
  .o_par_fault(o_par_fault), .i_motor_pos(i_motor_pos), .i_second_capture_input(i_second_capture_input),
  .i_enable(i_enable), .i_err_class(i_err_class), .i_safe_torque_off(i_safe_torque_off),
  .o_brake_release(o_brake_release), .o_motor_current_on(o_motor_current_on),
  .o_operation_enabled(o_operation_enabled), .o_brake_state(o_brake_state));
`default_nettype wire

// *** verification/sbcm_brake_model.sv ***
// holding brake model: grips a few cycles after its coil drops
// assumes the coil follows o_brake_release of the monitor
`timescale 1ns/100ps
`default_nettype none
module sbcm_brake_model #(
  parameter int ENGAGE_CYCLES = 6
) (
  input wire logic i_clock,
  input wire logic i_coil_on,
  output logic o_engaged = 1'h1
);
  int hold_cnt = 0;
  // ========================================
  // mechanical lag, so a cut that comes too soon leaves the load free
  always_ff @(posedge i_clock) begin
    if (i_coil_on) begin
      hold_cnt <= 0;
      o_engaged <= 1'h0;
    end else if (hold_cnt < ENGAGE_CYCLES) begin
      hold_cnt <= hold_cnt + 1;
    end else begin
      o_engaged <= 1'h1;
    end
  end
endmodule : sbcm_brake_model
`default_nettype wire

// *** verification/sbcm_monitor_test.sv ***
// self-checking bench of the standstill, brake and capture monitor
// assumes short ms tick (10 cycles) and 2 ms brake delays
`timescale 1ns/100ps
`default_nettype none
`include "sbcm_cfg.svh"
module sbcm_monitor_test;
  import sbcm_pkg::*;
  localparam logic [15:0] A_ST = `SBCM_ADDR_CAP_STATUS;
  localparam logic [15:0] A_CP = `SBCM_ADDR_SECOND_CAPTURE_INPUT_POS;
  localparam logic [15:0] A_WN = `SBCM_ADDR_WIN_SIZE;
  localparam logic [15:0] A_DW = `SBCM_ADDR_DWELL;
  localparam logic [15:0] A_TO = `SBCM_ADDR_TIMEOUT;
  localparam logic [31:0] Z = 32'h0;
  logic i_clock = 1'h0, i_sys_rst = 1'h1, i_par_rd = 1'h0, i_par_wr = 1'h0;
  logic [15:0] i_par_addr = 16'h0;
  logic [31:0] i_par_wdata = Z, i_motor_pos = Z, i_pos_shift = Z, i_pos_dev = Z;
  logic i_first_capture_input = 1'h0, i_second_capture_input = 1'h0, i_first_capture_input_arm = 1'h0;
  logic i_second_capture_input_arm = 1'h0, i_pos_redefine = 1'h0, i_move_start = 1'h0;
  logic i_target_reached = 1'h0, i_profile_done = 1'h0, i_enable = 1'h0;
  logic i_safe_torque_off = 1'h0;
  logic [2:0] i_err_class = 3'h0;
  logic [31:0] o_par_rdata;
  logic o_par_ack, o_par_fault, o_proc_done, o_standstill_err, o_brake_release;
  logic o_motor_current_on, o_operation_enabled, brake_engaged;
  sbcm_brk_e o_brake_state;
  int bad_count = 0;
  int total_checks = 0;
  sbcm_monitor #(.TICK_CYCLES(10), .BRAKE_RELEASE_MS(16'h2), .BRAKE_APPLY_MS(16'h2)) uut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_par_addr(i_par_addr), .i_par_rd(i_par_rd),
    .i_par_wr(i_par_wr), .i_par_wdata(i_par_wdata), .o_par_rdata(o_par_rdata), .o_par_ack(o_par_ack),
    .o_par_fault(o_par_fault), .i_motor_pos(i_motor_pos), .i_first_capture_input(i_first_capture_input),
    .i_second_capture_input(i_second_capture_input), .i_first_capture_input_arm(i_first_capture_input_arm), .i_second_capture_input_arm(i_second_capture_input_arm),
    .i_pos_redefine(i_pos_redefine), .i_pos_shift(i_pos_shift), .i_move_start(i_move_start),
    .i_target_reached(i_target_reached), .i_profile_done(i_profile_done), .i_pos_dev(i_pos_dev),
    .o_proc_done(o_proc_done), .o_standstill_err(o_standstill_err), .i_enable(i_enable),
    .i_err_class(i_err_class), .i_safe_torque_off(i_safe_torque_off), .o_brake_release(o_brake_release),
    .o_motor_current_on(o_motor_current_on), .o_operation_enabled(o_operation_enabled),
    .o_brake_state(o_brake_state));
  sbcm_brake_model u_brake (.i_clock(i_clock), .i_coil_on(o_brake_release), .o_engaged(brake_engaged));
  // ========================================
  // 125 MHz clock
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  // ========================================
  // compare, drive and wait helpers; all start and end at a falling edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic wt(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v) begin
      @(negedge i_clock);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("Error at %0t: wait ran out, got %h expected %h", $time, s, v);
        test_done();
      end
    end
  endtask : wt
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge i_clock);
    s = 1'h0;
  endtask : pulse
  // one parameter access; rdata judged only on a good read
  task automatic par(input logic [15:0] a, input logic wr, input logic [31:0] d,
      input logic [31:0] exp, input logic flt);
    i_par_addr = a;
    i_par_wr = wr;
    i_par_rd = !wr;
    i_par_wdata = d;
    @(negedge i_clock);
    i_par_wr = 1'h0;
    i_par_rd = 1'h0;
    chkb(o_par_ack, 1'h1);
    chkb(o_par_fault, flt);
    if (!wr && !flt) chk(o_par_rdata, exp);
    // idle cycle, so a following call never raises a strobe in the step that lowered it
    @(negedge i_clock);
  endtask : par
  // ========================================
  // scenarios
  task automatic t_regs();
    par(A_ST, 1'h0, Z, Z, 1'h0);
    par(A_CP, 1'h0, Z, Z, 1'h0);
    par(A_WN, 1'h0, Z, 32'hA, 1'h0);
    par(A_DW, 1'h0, Z, Z, 1'h0);
    par(A_TO, 1'h0, Z, Z, 1'h0);
    par(A_WN, 1'h1, 32'h8000, Z, 1'h1);
    par(A_WN, 1'h1, 32'h7FFF, Z, 1'h0);
    par(A_WN, 1'h0, Z, 32'h7FFF, 1'h0);
    par(A_DW, 1'h1, 32'h8000, Z, 1'h1);
    par(A_TO, 1'h1, 32'h3E81, Z, 1'h1);
    par(A_TO, 1'h1, 32'h3E80, Z, 1'h0);
    par(A_TO, 1'h0, Z, 32'h3E80, 1'h0);
    par(A_ST, 1'h1, 32'h3, Z, 1'h1);
    par(16'h0A04, 1'h0, Z, Z, 1'h1);
  endtask : t_regs
  task automatic t_cap();
    i_motor_pos = 32'hFFFF_FF00;
    pulse(i_first_capture_input);
    par(A_ST, 1'h0, Z, 32'h1, 1'h0);
    pulse(i_second_capture_input);
    par(A_CP, 1'h0, Z, 32'hFFFF_FF00, 1'h0);
    par(A_ST, 1'h0, Z, 32'h3, 1'h0);
    i_motor_pos = 32'h1234;
    i_pos_shift = 32'h200;
    pulse(i_pos_redefine);
    par(A_CP, 1'h1, 32'h5, Z, 1'h1);
    par(A_CP, 1'h0, Z, 32'h100, 1'h0);
    pulse(i_second_capture_input_arm);
    par(A_ST, 1'h0, Z, 32'h1, 1'h0);
    pulse(i_first_capture_input_arm);
    par(A_ST, 1'h0, Z, Z, 1'h0);
  endtask : t_cap
  task automatic t_stand();
    int n;
    par(A_WN, 1'h1, 32'hA, Z, 1'h0);
    par(A_TO, 1'h1, Z, Z, 1'h0);
    i_pos_dev = 32'h64;
    pulse(i_move_start);
    pulse(i_target_reached);
    wt(o_proc_done, 1'h1, 2, n);
    par(A_DW, 1'h1, 32'h3, Z, 1'h0);
    pulse(i_move_start);
    chkb(o_proc_done, 1'h0);
    pulse(i_profile_done);
    repeat (60) @(negedge i_clock);
    chkb(o_proc_done, 1'h0);
    chkb(o_standstill_err, 1'h0);
    i_pos_dev = 32'hFFFF_FFF6;
    wt(o_proc_done, 1'h1, 40, n);
    chkb(n >= 20, 1'h1);
    par(A_TO, 1'h1, 32'h2, Z, 1'h0);
    i_pos_dev = 32'hB;
    pulse(i_move_start);
    repeat (40) @(negedge i_clock);
    chkb(o_standstill_err, 1'h0);
    pulse(i_target_reached);
    wt(o_standstill_err, 1'h1, 30, n);
    chkb(n >= 10, 1'h1);
    chkb(o_proc_done, 1'h0);
  endtask : t_stand
  // brake up to operation enabled, release delay measured
  task automatic run_up();
    int n;
    i_err_class = 3'h0;
    i_safe_torque_off = 1'h0;
    i_enable = 1'h1;
    wt(o_brake_release, 1'h1, 2, n);
    chkb(o_motor_current_on, 1'h1);
    wt(o_operation_enabled, 1'h1, 40, n);
    chkb(n >= 8, 1'h1);
    chk(32'(o_brake_state), 32'(BRK_RUN));
  endtask : run_up
  task automatic delayed_cut(input logic [2:0] cls, input logic en);
    int n;
    run_up();
    i_err_class = cls;
    i_enable = en;
    wt(o_brake_release, 1'h0, 2, n);
    chkb(o_motor_current_on, 1'h1);
    chk(32'(o_brake_state), 32'(BRK_APPLY));
    wt(o_motor_current_on, 1'h0, 40, n);
    chkb(n >= 8, 1'h1);
    chkb(brake_engaged, 1'h1);
  endtask : delayed_cut
  task automatic fast_cut(input logic [2:0] cls, input logic safe_torque_off);
    run_up();
    i_err_class = cls;
    i_safe_torque_off = safe_torque_off;
    @(negedge i_clock);
    chkb(o_motor_current_on, 1'h0);
    chkb(o_brake_release, 1'h0);
    chkb(brake_engaged, 1'h0);
    chk(32'(o_brake_state), 32'(BRK_OFF));
  endtask : fast_cut
  // ========================================
  // main sequence
  initial begin
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'h0;
    t_regs();
    t_cap();
    t_stand();
    delayed_cut(3'h2, 1'h1);
    delayed_cut(3'h0, 1'h0);
    fast_cut(3'h3, 1'h0);
    fast_cut(3'h4, 1'h0);
    fast_cut(3'h0, 1'h1);
    test_done();
  end
endmodule : sbcm_monitor_test
`default_nettype wire
